// >>> core/perf_event_counter_select.sv
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Count only while core runs or is snooped.
// - Cycle events under 3CH stop when halted.
// - Bits 15:14 choose own core or both.
// - Value 11B counts shared condition from all cores.
// - Unit mask 20H counts all bus agents.
// - 30H counts second-level reject cycles.
// - 32H counts second-level idle request cycles.
// - 3C/00H counts active core clock cycles.
// - 3C/01H counts active bus clock cycles.
// - 3C/02H counts bus cycles, other core halted.
// - 4FH counts prefetch requests, retries included.
// - 78H/01H counts cross-core share snoops.
// - Share snoops use store port, may stall stores.
// - 7DH counts bus cycles with nothing pending.
// - 77H counts clean, hit, hit-modified responses.
module perf_event_counter_select
   import perf_evt_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // AXI4-Lite write address
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [3:0]  i_awaddr,
   // AXI4-Lite write data
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   // AXI4-Lite write response
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic [1:0]       o_bresp,
   // AXI4-Lite read address
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [3:0]  i_araddr,
   // AXI4-Lite read data
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   // Core state, own core [0] and other core [1]
   input  wire logic [1:0]  i_core_running,
   input  wire logic [1:0]  i_core_snooped,
   // Bus clock tick, sampled on the core clock
   input  wire logic        i_bus_tick,
   // Event conditions and store request; two-bit ones own [0] and other [1]
   input  wire logic [1:0]  i_l2_reject,
   input  wire logic [1:0]  i_l2_idle,
   input  wire logic [1:0]  i_pref_req,
   input  wire logic [1:0]  i_share_snoop,
   input  wire logic [1:0]  i_bus_idle,
   input  wire logic [1:0]  i_bus_drdy,
   input  wire logic        i_bus_drdy_others,
   input  wire logic        i_snoop_resp,
   input  wire logic        i_store_req,
   // Data cache store port
   output logic             o_store_grant,
   output logic             o_snoop_port,
   // Counter view
   output logic [31:0]      o_count
);
   ////////////////////////////////////////////////////////////////////////
   logic [1:0] run_s, snp_s, rej_s, idl_s, prf_s, shs_s, bid_s, drd_s;
   logic       tick_s, oth_s, rsp_s, str_s;
   logic       tick_prev_q;

   perf_evt_sync #(.W(20)) u_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async ({i_core_running, i_core_snooped, i_l2_reject, i_l2_idle, i_pref_req,
                 i_share_snoop, i_bus_idle, i_bus_drdy, i_bus_tick, i_bus_drdy_others,
                 i_snoop_resp, i_store_req}),
      .o_sync  ({run_s, snp_s, rej_s, idl_s, prf_s, shs_s, bid_s, drd_s, tick_s, oth_s,
                 rsp_s, str_s})
   );

   ////////////////////////////////////////////////////////////////////////
   // Register file
   logic [31:0] select_q, select_d;
   logic [31:0] count_q, count_d;
   logic        bvalid_q, bvalid_d;
   logic [1:0]  bresp_q, bresp_d;
   logic        rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  rresp_q, rresp_d;
   logic        aw_held_q, aw_held_d;
   logic [3:0]  awaddr_q, awaddr_d;
   logic        w_held_q, w_held_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0]  wstrb_q, wstrb_d;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction : merge

   logic [7:0] evt_code, umask;
   logic [1:0] spec;
   logic       enable;
   assign evt_code = select_q[SEL_EVT_LSB +: 8];
   assign umask    = select_q[SEL_UM_LSB +: 8];
   assign spec     = select_q[SEL_SPEC_LSB +: 2];
   assign enable   = select_q[SEL_EN_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Event selection
   logic active, bus_edge, pick, hit, all_cores;
   logic [1:0] core_en;

   // Snooped cores stay active even if halted
   assign active   = run_s[0] | snp_s[0];
   assign bus_edge = tick_s & ~tick_prev_q;
   // Core attribution from the top unit-mask bits
   assign all_cores = (spec == CORE_SPEC_ALL);
   assign core_en   = all_cores ? 2'h3 : 2'h1;

   function automatic logic attr(input logic [1:0] src, input logic [1:0] en);
      return |(src & en);
   endfunction : attr

   always_comb begin
      pick = 1'b0;
      case (evt_code)
         EVT_L2_REJECT:   pick = attr(rej_s, core_en);
         EVT_L2_IDLE:     pick = attr(idl_s, core_en);
         EVT_PREF_REQ:    pick = attr(prf_s, core_en);
         EVT_SHARE_SNOOP: pick = (umask == UM_SHARE_SNOOP) & shs_s[0];
         EVT_BUS_IDLE:    pick = bus_edge & attr(bid_s, core_en);
         EVT_SNOOP_RESP:  pick = rsp_s;
         EVT_BUS_DRDY:    pick = attr(drd_s, core_en) | ((umask[5:0] == UM_ALL_AGENTS[5:0]) & oth_s);
         EVT_CYCLES: begin
            // Halted core never counts cycles, even when snooped
            case (umask[5:0])
               UM_CORE_CYC[5:0]:   pick = run_s[0];
               UM_REF_CYC[5:0]:    pick = run_s[0] & bus_edge;
               UM_SERIAL_CYC[5:0]: pick = run_s[0] & ~run_s[1] & bus_edge;
               default:            pick = 1'b0;
            endcase
         end
         default: pick = 1'b0;
      endcase
   end
   assign hit = enable & active & pick;

   ////////////////////////////////////////////////////////////////////////
   // Snoops take the store port; stores wait
   assign o_snoop_port  = shs_s[0];
   assign o_store_grant = str_s & ~shs_s[0];

   ////////////////////////////////////////////////////////////////////////
   // Bus slave
   logic wr_go, rd_go;
   assign o_awready = ~aw_held_q & ~bvalid_q;
   assign o_wready  = ~w_held_q & ~bvalid_q;
   assign o_arready = ~rvalid_q;
   assign wr_go = (aw_held_q | (i_awvalid & o_awready)) & (w_held_q | (i_wvalid & o_wready));
   assign rd_go = i_arvalid & o_arready;

   // Write beat: held copy if taken earlier, else the live bus
   logic [3:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   assign wr_addr = aw_held_q ? awaddr_q : i_awaddr;
   assign wr_data = w_held_q ? wdata_q : i_wdata;
   assign wr_strb = w_held_q ? wstrb_q : i_wstrb;

   always_comb begin
      select_d  = select_q;
      count_d   = count_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      aw_held_d = aw_held_q;
      awaddr_d  = awaddr_q;
      w_held_d  = w_held_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      if (i_awvalid & o_awready) begin
         aw_held_d = 1'b1;
         awaddr_d  = i_awaddr;
      end
      if (i_wvalid & o_wready) begin
         w_held_d = 1'b1;
         wdata_d  = i_wdata;
         wstrb_d  = i_wstrb;
      end
      // One step per qualifying cycle
      if (hit) count_d = count_q + 32'h1;
      if (wr_go) begin
         aw_held_d = 1'b0;
         w_held_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = RESP_OKAY;
         case (wr_addr)
            ADDR_SELECT: select_d = merge(select_q, wr_data, wr_strb);
            // Software write beats a same-cycle increment
            ADDR_COUNT:  count_d = merge(count_q, wr_data, wr_strb);
            ADDR_STATUS: bresp_d = RESP_OKAY;
            default:     bresp_d = RESP_SLVERR;
         endcase
      end
      if (bvalid_q & i_bready) bvalid_d = 1'b0;
      if (rd_go) begin
         rvalid_d = 1'b1;
         rresp_d  = RESP_OKAY;
         case (i_araddr)
            ADDR_SELECT: rdata_d = select_q;
            ADDR_COUNT:  rdata_d = count_q;
            ADDR_STATUS: rdata_d = {28'h0, run_s[1], run_s[0], snp_s[0], active};
            default: begin
               rdata_d = 32'h0;
               rresp_d = RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q & i_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         select_q    <= SELECT_RST;
         count_q     <= 32'h0;
         bvalid_q    <= 1'b0;
         bresp_q     <= RESP_OKAY;
         rvalid_q    <= 1'b0;
         rdata_q     <= 32'h0;
         rresp_q     <= RESP_OKAY;
         aw_held_q   <= 1'b0;
         awaddr_q    <= 4'h0;
         w_held_q    <= 1'b0;
         wdata_q     <= 32'h0;
         wstrb_q     <= 4'h0;
         tick_prev_q <= 1'b0;
      end else begin
         select_q    <= select_d;
         count_q     <= count_d;
         bvalid_q    <= bvalid_d;
         bresp_q     <= bresp_d;
         rvalid_q    <= rvalid_d;
         rdata_q     <= rdata_d;
         rresp_q     <= rresp_d;
         aw_held_q   <= aw_held_d;
         awaddr_q    <= awaddr_d;
         w_held_q    <= w_held_d;
         wdata_q     <= wdata_d;
         wstrb_q     <= wstrb_d;
         tick_prev_q <= tick_s;
      end
   end

   assign o_bvalid = bvalid_q;
   assign o_bresp  = bresp_q;
   assign o_rvalid = rvalid_q;
   assign o_rdata  = rdata_q;
   assign o_rresp  = rresp_q;
   assign o_count  = count_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_hold_inactive;
      @(posedge i_clk) disable iff (i_rst)
      (!active && !wr_go) |=> (count_q == $past(count_q));
   endproperty
   a_hold_inactive: assert property (p_hold_inactive) else $error("count moved while core inactive");

   property p_halt_no_cycles;
      @(posedge i_clk) disable iff (i_rst)
      (evt_code == EVT_CYCLES && !run_s[0] && !wr_go) |=> $stable(count_q);
   endproperty
   a_halt_no_cycles: assert property (p_halt_no_cycles) else $error("cycle event counted on halted core");

   property p_step_one;
      @(posedge i_clk) disable iff (i_rst)
      (hit && !wr_go) |=> (count_q == $past(count_q) + 32'h1);
   endproperty
   a_step_one: assert property (p_step_one) else $error("counter did not step by one");

   property p_core_cycles;
      @(posedge i_clk) disable iff (i_rst)
      (enable && evt_code == EVT_CYCLES && umask[5:0] == UM_CORE_CYC[5:0] && run_s[0] && !wr_go)
      |=> (count_q == $past(count_q) + 32'h1);
   endproperty
   a_core_cycles: assert property (p_core_cycles) else $error("core cycle missed");

   property p_ref_on_tick;
      @(posedge i_clk) disable iff (i_rst)
      (evt_code == EVT_CYCLES && umask[5:0] == UM_REF_CYC[5:0] && !bus_edge && !wr_go) |=> $stable(count_q);
   endproperty
   a_ref_on_tick: assert property (p_ref_on_tick) else $error("reference count off bus tick");

   property p_serial;
      @(posedge i_clk) disable iff (i_rst)
      (evt_code == EVT_CYCLES && umask[5:0] == UM_SERIAL_CYC[5:0] && run_s[1] && !wr_go) |=> $stable(count_q);
   endproperty
   a_serial: assert property (p_serial) else $error("serial cycles counted with other core running");

   property p_own_only;
      @(posedge i_clk) disable iff (i_rst)
      (enable && active && !all_cores && evt_code == EVT_L2_REJECT && !rej_s[0] && !wr_go) |=> $stable(count_q);
   endproperty
   a_own_only: assert property (p_own_only) else $error("other core counted without all-cores mask");

   property p_all_cores;
      @(posedge i_clk) disable iff (i_rst)
      (enable && active && all_cores && evt_code == EVT_L2_IDLE && idl_s[1] && !wr_go)
      |=> (count_q == $past(count_q) + 32'h1);
   endproperty
   a_all_cores: assert property (p_all_cores) else $error("shared condition missed with all-cores mask");

   property p_store_port;
      @(posedge i_clk) disable iff (i_rst)
      o_snoop_port |-> !o_store_grant;
   endproperty
   a_store_port: assert property (p_store_port) else $error("store granted during snoop");

   property p_snoop_resp;
      @(posedge i_clk) disable iff (i_rst)
      (enable && active && evt_code == EVT_SNOOP_RESP && rsp_s && !wr_go) |=> (count_q == $past(count_q) + 32'h1);
   endproperty
   a_snoop_resp: assert property (p_snoop_resp) else $error("snoop response missed");

   property p_bus_idle_tick;
      @(posedge i_clk) disable iff (i_rst)
      (evt_code == EVT_BUS_IDLE && !bus_edge && !wr_go) |=> $stable(count_q);
   endproperty
   a_bus_idle_tick: assert property (p_bus_idle_tick) else $error("bus idle counted off bus tick");

   property p_share_snoop;
      @(posedge i_clk) disable iff (i_rst)
      (enable && active && evt_code == EVT_SHARE_SNOOP && umask == UM_SHARE_SNOOP && shs_s[0] && !wr_go)
      |=> (count_q == $past(count_q) + 32'h1);
   endproperty
   a_share_snoop: assert property (p_share_snoop) else $error("share snoop missed");

   property p_drdy_agents;
      @(posedge i_clk) disable iff (i_rst)
      (enable && active && evt_code == EVT_BUS_DRDY && umask[5:0] == UM_ALL_AGENTS[5:0] && oth_s && !wr_go)
      |=> (count_q == $past(count_q) + 32'h1);
   endproperty
   a_drdy_agents: assert property (p_drdy_agents) else $error("other agent data ready missed");
endmodule : perf_event_counter_select

// >>> core/perf_evt_pkg.sv
package perf_evt_pkg;
   // Event codes
   localparam logic [7:0] EVT_L2_REJECT    = 8'h30;
   localparam logic [7:0] EVT_L2_IDLE      = 8'h32;
   localparam logic [7:0] EVT_CYCLES       = 8'h3C;
   localparam logic [7:0] EVT_PREF_REQ     = 8'h4F;
   localparam logic [7:0] EVT_SNOOP_RESP   = 8'h77;
   localparam logic [7:0] EVT_SHARE_SNOOP  = 8'h78;
   localparam logic [7:0] EVT_BUS_IDLE     = 8'h7D;
   localparam logic [7:0] EVT_BUS_DRDY     = 8'h62;
   // Unit masks
   localparam logic [7:0] UM_CORE_CYC      = 8'h00;
   localparam logic [7:0] UM_REF_CYC       = 8'h01;
   localparam logic [7:0] UM_SERIAL_CYC    = 8'h02;
   localparam logic [7:0] UM_SHARE_SNOOP   = 8'h01;
   localparam logic [7:0] UM_ALL_AGENTS    = 8'h20;
   localparam logic [1:0] CORE_SPEC_ALL    = 2'h3;
   // Event-select field layout
   localparam int SEL_EVT_LSB  = 0;
   localparam int SEL_UM_LSB   = 8;
   localparam int SEL_SPEC_LSB = 14;
   localparam int SEL_EN_BIT   = 22;
   // Register map, byte addresses
   localparam logic [3:0] ADDR_SELECT  = 4'h0;
   localparam logic [3:0] ADDR_COUNT   = 4'h4;
   localparam logic [3:0] ADDR_STATUS  = 4'h8;
   localparam logic [31:0] SELECT_RST  = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   localparam int CNT_W = 32;
endpackage : perf_evt_pkg

// >>> core/perf_evt_sync.sv
`timescale 1ns/1ps
module perf_evt_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   // Two stages; first is read only by the second
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end
   assign o_sync = sync_q;
endmodule : perf_evt_sync

// >>> verification/perf_evt_far_model.sv
`timescale 1ns/1ps
module perf_evt_far_model (
   // Clock
   input  wire logic  i_clk,
   // Core state and event levels, own [0] other [1]
   output logic [1:0]      o_core_running,
   output logic [1:0]      o_core_snooped,
   output logic            o_bus_tick,
   output logic [7:0][1:0] o_ev,
   output logic            o_store_req
);
   initial begin
      o_core_running = 2'h0;
      o_core_snooped = 2'h0;
      o_bus_tick     = 1'b0;
      o_ev           = '0;
      o_store_req    = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic set_core(input logic [1:0] run, input logic [1:0] snp, input logic st);
      @(posedge i_clk);
      o_core_running <= run;
      o_core_snooped <= snp;
      o_store_req    <= st;
   endtask : set_core
   // Kind 0..7 event level, 8 core run, 9 bus ticks with bus idle level
   task automatic stim(input int kind, input logic [1:0] lanes, input int n);
      logic [1:0] keep;
      keep = o_core_running;
      @(posedge i_clk);
      if (kind == 8) o_core_running <= lanes;
      else o_ev[(kind == 9) ? 4 : kind] <= lanes;
      if (kind == 9) begin
         // Two cycles per phase so the synchronizer sees every edge
         repeat (n) begin
            o_bus_tick <= 1'b1;
            repeat (2) @(posedge i_clk);
            o_bus_tick <= 1'b0;
            repeat (2) @(posedge i_clk);
         end
      end else repeat (n) @(posedge i_clk);
      if (kind == 8) o_core_running <= keep;
      else o_ev[(kind == 9) ? 4 : kind] <= 2'h0;
   endtask : stim
endmodule : perf_evt_far_model

// >>> verification/test_perf_event_counter_select.sv
`timescale 1ns/1ps
module test_perf_event_counter_select;
   import perf_evt_pkg::*;
   logic i_clk, i_rst, awvalid, wvalid, bready, arvalid, rready;
   logic [3:0] awaddr, araddr;
   logic [31:0] wdata, rd;
   logic [1:0] rs, bs, bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, grant, sport;
   logic [31:0] rdata, count;
   logic [1:0] run, snp;
   logic tick, streq;
   logic [7:0][1:0] ev;
   int err_count = 0;
   int comparisons = 0;
   perf_evt_far_model far_u (.i_clk(i_clk), .o_core_running(run), .o_core_snooped(snp),
      .o_bus_tick(tick), .o_ev(ev), .o_store_req(streq));
   perf_event_counter_select dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_awvalid(awvalid),
      .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
      .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
      .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
      .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_core_running(run),
      .i_core_snooped(snp), .i_bus_tick(tick), .i_l2_reject(ev[0]), .i_l2_idle(ev[1]),
      .i_pref_req(ev[2]), .i_share_snoop(ev[3]), .i_bus_idle(ev[4]), .i_bus_drdy(ev[5]),
      .i_bus_drdy_others(ev[7][0]), .i_snoop_resp(ev[6][0]), .i_store_req(streq),
      .o_store_grant(grant), .o_snoop_port(sport), .o_count(count));
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Master holds each channel until its own ready; no cycle count assumed
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 0;
      w = 0;
      @(posedge i_clk);
      {awvalid, wvalid, bready} <= 3'h7;
      awaddr <= a;
      wdata <= d;
      while (!(aw && w)) begin
         @(posedge i_clk);
         if (!aw && awready) begin
            aw = 1;
            awvalid <= 1'b0;
         end
         if (!w && wready) begin
            w = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge i_clk); while (!bvalid);
      bs = bresp;
      bready <= 1'b0;
   endtask : axi_write
   task automatic axi_read(input logic [3:0] a);
      @(posedge i_clk);
      arvalid <= 1'b1;
      rready <= 1'b1;
      araddr <= a;
      do @(posedge i_clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge i_clk); while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : axi_read
   function automatic logic [31:0] mk(input logic [7:0] code, input logic [7:0] um);
      return {9'h000, 1'b1, 6'h00, um, code};
   endfunction : mk
   task automatic run_case(input string nm, input logic [31:0] sel, input int kind,
                           input logic [1:0] lanes, input int n, input logic [31:0] exp);
      axi_write(ADDR_SELECT, sel);
      axi_write(ADDR_COUNT, 32'h0000_0000);
      far_u.stim(kind, lanes, n);
      repeat (6) @(posedge i_clk);
      axi_read(ADDR_COUNT);
      check(nm, rd, exp);
      check({nm, " port"}, count, exp);
      $display("test %s done", nm);
   endtask : run_case
   ////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      err_count++;
      give_verdict();
   end
   initial begin
      {i_rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
      {awaddr, araddr, wdata} = '0;
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      axi_read(ADDR_COUNT);
      check("count reset", rd, 32'h0000_0000);
      axi_read(4'hC);
      check("unmapped resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
      axi_write(4'hC, 32'h0000_0000);
      check("unmapped write resp", {30'h0, bs}, {30'h0, RESP_SLVERR});
      far_u.set_core(2'h1, 2'h0, 1'b0);
      run_case("reject", mk(8'h30, 8'h00), 0, 2'h1, 5, 5);
      run_case("disabled", 32'h0000_0030, 0, 2'h1, 5, 0);
      run_case("l2_idle", mk(8'h32, 8'h00), 1, 2'h1, 6, 6);
      run_case("prefetch", mk(8'h4F, 8'h00), 2, 2'h1, 7, 7);
      run_case("share", mk(8'h78, 8'h01), 3, 2'h1, 4, 4);
      run_case("snoop_resp", mk(8'h77, 8'h00), 6, 2'h1, 3, 3);
      run_case("other_own", mk(8'h30, 8'h00), 0, 2'h2, 5, 0);
      run_case("other_all", mk(8'h30, 8'hC0), 0, 2'h2, 5, 5);
      run_case("drdy_all", mk(8'h62, 8'h20), 7, 2'h1, 4, 4);
      run_case("drdy_own", mk(8'h62, 8'h00), 7, 2'h1, 4, 0);
      run_case("drdy_core", mk(8'h62, 8'h00), 5, 2'h1, 4, 4);
      run_case("ref_cyc", mk(8'h3C, 8'h01), 9, 2'h0, 3, 3);
      run_case("serial", mk(8'h3C, 8'h02), 9, 2'h0, 3, 3);
      run_case("bus_idle", mk(8'h7D, 8'h00), 9, 2'h1, 3, 3);
      far_u.set_core(2'h3, 2'h0, 1'b0);
      run_case("serial_both", mk(8'h3C, 8'h02), 9, 2'h0, 3, 0);
      far_u.set_core(2'h0, 2'h0, 1'b0);
      run_case("core_cyc", mk(8'h3C, 8'h00), 8, 2'h1, 9, 9);
      run_case("inactive", mk(8'h30, 8'h00), 0, 2'h1, 5, 0);
      far_u.set_core(2'h0, 2'h1, 1'b0);
      run_case("snooped", mk(8'h30, 8'h00), 0, 2'h1, 5, 5);
      run_case("snoop_halt", mk(8'h3C, 8'h00), 0, 2'h0, 8, 0);
      far_u.set_core(2'h1, 2'h0, 1'b1);
      repeat (4) @(posedge i_clk);
      check("store grant", {31'h0, grant}, 32'h1);
      axi_read(ADDR_STATUS);
      check("status", rd, 32'h0000_0005);
      fork
         far_u.stim(3, 2'h1, 8);
         begin
            repeat (6) @(posedge i_clk);
            check("grant in snoop", {31'h0, grant}, 32'h0);
            check("snoop port", {31'h0, sport}, 32'h1);
         end
      join
      $display("test store_port done");
      give_verdict();
   end
endmodule : test_perf_event_counter_select
